// >>> rst_irq_pkg.sv
// Constants and types for the reset and interrupt control block
// How it works
// - Reset when pin, power-on, watchdog or brownout source asserts.
// - After reset, fetch address comes from vector FFFEh-FFFFh.
// - Internal reset sources pull the open-drain reset pin low.
// - Reset state lasts at least 4096 clocks; outputs take reset values.
// - External reset pin is detected asynchronously, without a clock.
// - Pin still low at period end keeps device in reset.
// - Wait 4096 clocks for oscillator after reset and after halt exit.
// - Brownout reset is static, with hysteresis, pin held low throughout.
// - Global mask is set right after reset.
// - Maskable requests serviced only when mask clear; otherwise stay latched.
// - Entry: finish instruction, push PC X A CC, set mask, load vector.
// - Return from service pops registers, clearing mask, resuming program.
// - Simultaneous pending requests resolved by fixed vector-position priority.
// - Any interrupt wakes wait; only external ones wake halt.
// - Software trap enters servicing regardless of the mask.
// - Edge external request latched on edge, cleared on service entry.
// - External pins are each inverted on their own before edge detection, one vector per pin.
// - Peripheral flag interrupts only with mask clear and enable set.
// - Clearing sequence resets the internal latch, discarding pending request.
// - Global mask is bit 3 of condition code register.
// - Y index is never pushed or popped by entry or return.
package rst_irq_pkg;

  // ******************************
  // Sizes and timing
  // ******************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RESET_HOLD_CYCLES = 4096;
  localparam int unsigned STAB_CYCLES = 4096;
  localparam int unsigned NUM_EXT = 4;
  localparam int unsigned NUM_PERIPH = 4;
  localparam int unsigned NUM_SRC = NUM_EXT + NUM_PERIPH;
  localparam int unsigned CCR_MASK_BIT = 3;

  // ******************************
  // Vectors, highest priority first
  // ******************************
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_EXT0 = 16'hFFF6;
  localparam logic [15:0] VEC_PERIPH0 = 16'hFFEC;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  // ******************************
  // Condition code and Avalon map
  // ******************************
  localparam logic [7:0] CCR_RESET = 8'hE8;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PEND = 4'h4;
  localparam logic [3:0] ADDR_ENABLE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [31:0] UNMAPPED_DATA = 32'hDEAD_0000;

  // Entry/return sequencer; Gray codes in declaration order
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PUSH = 3'b001,
    ST_VECTOR = 3'b011,
    ST_POP = 3'b010,
    ST_WAIT = 3'b110,
    ST_HALT = 3'b111,
    ST_STAB = 3'b101
  } seq_state_t;

endpackage

// >>> reset_pin_sync.sv
// Reset request gathering and release synchroniser
`timescale 1ns/100ps
module reset_pin_sync (
  input wire logic sys_clk_in,
  input wire logic reset_pin_n_in,
  input wire logic por_in,
  input wire logic watchdog_in,
  input wire logic brownout_detector_in,
  output logic any_reset_out,
  output logic pin_low_out
);
  import rst_irq_pkg::*;

  logic async_req;
  logic sync1_q;
  logic sync2_q;
  logic pin1_q;
  logic pin2_q;

  assign async_req = por_in | watchdog_in | brownout_detector_in | ~reset_pin_n_in;

  always_ff @(posedge sys_clk_in or posedge async_req) begin
    if (async_req) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= 1'b0;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    pin1_q <= ~reset_pin_n_in;
    pin2_q <= pin1_q;
  end

  assign any_reset_out = sync2_q;
  assign pin_low_out = pin2_q;
endmodule // reset_pin_sync

// >>> edge_latch.sv
// Edge or level request latch for one interrupt source
`timescale 1ns/100ps
module edge_latch (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic level_in,
  input wire logic edge_mode_in,
  input wire logic ack_in,
  input wire logic clear_in,
  output logic pend_out
);
  logic prev_q;
  logic pend_q;
  logic hit;

  assign hit = edge_mode_in ? (level_in & ~prev_q) : level_in;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (ce_in) begin
      prev_q <= level_in;
      if (hit) begin
        pend_q <= 1'b1;
      end else if (ack_in || clear_in) begin
        pend_q <= 1'b0;
      end
    end
  end

  assign pend_out = pend_q;
endmodule // edge_latch

// >>> reset_and_interrupt_control.sv
// Reset sequencing and interrupt dispatch top level
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module reset_and_interrupt_control #(
  parameter int unsigned RESET_HOLD = rst_irq_pkg::RESET_HOLD_CYCLES,
  parameter int unsigned STAB_HOLD = rst_irq_pkg::STAB_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_oe_out,
  input wire logic por_in,
  input wire logic watchdog_in,
  input wire logic brownout_detector_in,
  input wire logic [rst_irq_pkg::NUM_EXT-1:0] ext_pin_in,
  input wire logic [rst_irq_pkg::NUM_PERIPH-1:0] periph_flag_in,
  input wire logic insn_done_in,
  input wire logic trap_in,
  input wire logic return_from_service_in,
  input wire logic wfi_in,
  input wire logic halt_in,
  input wire logic set_mask_in,
  input wire logic clear_mask_in,
  output logic core_reset_out,
  output logic osc_enable_out,
  output logic cpu_run_out,
  output logic push_context_out,
  output logic pop_context_out,
  output logic vector_load_out,
  output logic [15:0] vector_addr_out,
  output logic [7:0] condition_code_register_out,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import rst_irq_pkg::*;

  // ******************************
  // Reset sequencing
  // ******************************
  localparam int CW = $clog2(RESET_HOLD + STAB_HOLD + 1);

  logic any_reset;
  logic pin_low;
  logic internal_src;
  logic [CW-1:0] hold_cnt_q;
  logic in_reset_q;
  logic drive_pin_q;

  reset_pin_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_pin_n_in(reset_pin_n_in),
    .por_in(por_in),
    .watchdog_in(watchdog_in),
    .brownout_detector_in(brownout_detector_in),
    .any_reset_out(any_reset),
    .pin_low_out(pin_low)
  );

  assign internal_src = por_in | watchdog_in | brownout_detector_in;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || any_reset) begin
      hold_cnt_q <= '0;
      in_reset_q <= 1'b1;
    end else if (ce_in && in_reset_q) begin
      if (hold_cnt_q < CW'(RESET_HOLD - 1)) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end else if (!pin_low) begin
        in_reset_q <= 1'b0;
        hold_cnt_q <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      drive_pin_q <= 1'b0;
    end else begin
      // Follows the sources only: holding on in_reset_q would lock the pin low forever
      drive_pin_q <= internal_src;
    end
  end

  assign reset_pin_n_out = 1'b0;
  assign reset_pin_oe_out = drive_pin_q | internal_src;
  assign core_reset_out = in_reset_q;

  // ******************************
  // Request latches
  // ******************************
  logic [NUM_EXT-1:0] ext_level;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] ack;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] edge_mode_q;
  logic [NUM_PERIPH-1:0] enable_q;
  logic [NUM_SRC-1:0] sw_clear;
  logic [NUM_EXT-1:0] ext1_q;
  logic [NUM_EXT-1:0] ext2_q;

  always_ff @(posedge sys_clk_in) begin
    ext1_q <= ext_pin_in;
    ext2_q <= ext1_q;
  end

  assign ext_level = ~ext2_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      edge_latch u_latch (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in | in_reset_q),
        .ce_in(ce_in),
        .level_in(gi < NUM_EXT ? ext_level[gi % NUM_EXT] : periph_flag_in[gi % NUM_PERIPH]),
        .edge_mode_in(edge_mode_q[gi]),
        .ack_in(ack[gi]),
        .clear_in(clr[gi]),
        .pend_out(pend[gi])
      );
    end
  endgenerate

  // ******************************
  // Mask, priority and sequencer
  // ******************************
  seq_state_t state_q;
  logic [7:0] ccr_q;
  logic mask;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] grant;
  logic trap_q;
  logic [CW-1:0] stab_cnt_q;
  logic [15:0] vec_q;
  logic [NUM_SRC-1:0] grant_q;
  logic boot_q;

  assign mask = ccr_q[CCR_MASK_BIT];

  // Peripherals need their enable bit; the mask is not applied here
  assign eligible = pend & {enable_q, {NUM_EXT{1'b1}}};

  always_comb begin
    grant = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  // Entry acknowledges edge latch
  // Winner frozen at push, so the acknowledged source matches the vector
  assign ack = (state_q == ST_VECTOR && !trap_q) ? grant_q : '0;
  assign clr = sw_clear;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || in_reset_q) begin
      ccr_q <= CCR_RESET;
    end else if (ce_in) begin
      if (state_q == ST_PUSH || set_mask_in) begin
        ccr_q[CCR_MASK_BIT] <= 1'b1;
      end else if (state_q == ST_POP || clear_mask_in) begin
        ccr_q[CCR_MASK_BIT] <= 1'b0;
      end else if ((wfi_in || halt_in) && state_q == ST_RUN) begin
        ccr_q[CCR_MASK_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || in_reset_q) begin
      state_q <= ST_STAB;
      stab_cnt_q <= '0;
      trap_q <= 1'b0;
      vec_q <= VEC_RESET;
      grant_q <= '0;
      boot_q <= 1'b1;
    end else if (ce_in) begin
      case (state_q)
        ST_RUN: begin
          if (insn_done_in && trap_in) begin
            trap_q <= 1'b1;
            state_q <= ST_PUSH;
          end else if (insn_done_in && !mask && |eligible) begin
            trap_q <= 1'b0;
            state_q <= ST_PUSH;
          end else if (return_from_service_in) begin
            state_q <= ST_POP;
          end else if (halt_in) begin
            state_q <= ST_HALT;
          end else if (wfi_in) begin
            state_q <= ST_WAIT;
          end
        end
        // Vector chosen here so it already stands while vector_load_out is high
        ST_PUSH: begin
          vec_q <= VEC_TRAP;
          grant_q <= '0;
          for (int i = 0; i < NUM_SRC; i++) begin
            if (grant[i] && !trap_q) begin
              grant_q <= grant;
              vec_q <= (i < NUM_EXT) ? VEC_EXT0 - 16'(i) * VEC_STEP
                                     : VEC_PERIPH0 - 16'(i - NUM_EXT) * VEC_STEP;
            end
          end
          state_q <= ST_VECTOR;
        end
        ST_VECTOR: begin
          boot_q <= 1'b0;
          state_q <= ST_RUN;
        end
        ST_POP: state_q <= ST_RUN;
        ST_WAIT: begin
          if (|eligible) begin
            trap_q <= 1'b0;
            state_q <= ST_PUSH;
          end
        end
        ST_HALT: begin
          if (|pend[NUM_EXT-1:0]) begin
            stab_cnt_q <= '0;
            state_q <= ST_STAB;
          end
        end
        ST_STAB: begin
          if (stab_cnt_q < CW'(STAB_HOLD - 1)) begin
            stab_cnt_q <= stab_cnt_q + 1'b1;
          end else if (boot_q) begin
            state_q <= ST_VECTOR;
            trap_q <= 1'b1;
          end else begin
            trap_q <= 1'b0;
            state_q <= ST_PUSH;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  assign vector_load_out = (state_q == ST_VECTOR);
  assign vector_addr_out = (state_q == ST_STAB) ? VEC_RESET : vec_q;
  assign push_context_out = (state_q == ST_PUSH);
  assign pop_context_out = (state_q == ST_POP);
  assign osc_enable_out = (state_q != ST_HALT);
  assign cpu_run_out = (state_q == ST_RUN) && !in_reset_q;
  assign condition_code_register_out = ccr_q;

  // ******************************
  // Avalon slave
  // ******************************
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      edge_mode_q <= '0;
      enable_q <= '0;
    end else if (ce_in && avs_write) begin
      if (avs_address == ADDR_CTRL) edge_mode_q <= avs_writedata[NUM_SRC-1:0];
      if (avs_address == ADDR_ENABLE) enable_q <= avs_writedata[NUM_PERIPH-1:0];
    end
  end

  assign sw_clear = (ce_in && avs_write && avs_address == ADDR_PEND) ? ~avs_writedata[NUM_SRC-1:0] : '0;

  // Reads take one wait state so data stands when waitrequest drops
  logic rd_valid_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      avs_readdata <= '0;
      rd_valid_q <= 1'b0;
    end else if (ce_in) begin
      rd_valid_q <= avs_read & ~rd_valid_q;
      if (avs_read && !rd_valid_q) begin
      case (avs_address)
        ADDR_CTRL: avs_readdata <= 32'(edge_mode_q);
        ADDR_PEND: avs_readdata <= 32'(pend);
        ADDR_ENABLE: avs_readdata <= 32'(enable_q);
        ADDR_STATUS: avs_readdata <= {16'h0000, 8'(ccr_q), 5'h00, state_q};
        default: avs_readdata <= UNMAPPED_DATA;
      endcase
      end
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & (~ce_in | (avs_read & ~rd_valid_q));

  // ******************************
  // Checks
  // ******************************
  property p_pin_low;
    @(posedge sys_clk_in) disable iff (srst_in) internal_src |-> reset_pin_oe_out && !reset_pin_n_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("Pin not driven on internal reset");

  property p_mask_after_reset;
    @(posedge sys_clk_in) disable iff (srst_in) in_reset_q |=> ccr_q[CCR_MASK_BIT];
  endproperty
  a_mask_after_reset: assert property (p_mask_after_reset) else $error("Mask clear after reset");

  property p_push_then_vector;
    @(posedge sys_clk_in) disable iff (srst_in || in_reset_q || !ce_in)
      state_q == ST_PUSH |=> state_q == ST_VECTOR && ccr_q[CCR_MASK_BIT];
  endproperty
  a_push_then_vector: assert property (p_push_then_vector) else $error("Entry order broken");

  property p_pop_clears;
    @(posedge sys_clk_in) disable iff (srst_in || in_reset_q || !ce_in || set_mask_in)
      state_q == ST_POP |=> !ccr_q[CCR_MASK_BIT];
  endproperty
  a_pop_clears: assert property (p_pop_clears) else $error("Return did not clear mask");

  property p_hold_pin;
    @(posedge sys_clk_in) disable iff (srst_in) in_reset_q && pin_low |=> in_reset_q;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("Left reset with pin low");

  property p_no_entry_masked;
    @(posedge sys_clk_in) disable iff (srst_in || in_reset_q || !ce_in)
      state_q == ST_RUN && mask && !trap_in |=> state_q != ST_PUSH;
  endproperty
  a_no_entry_masked: assert property (p_no_entry_masked) else $error("Entry while masked");

  property p_trap_entry;
    @(posedge sys_clk_in) disable iff (srst_in || in_reset_q || !ce_in)
      state_q == ST_RUN && insn_done_in && trap_in |=> state_q == ST_PUSH ##2 vec_q == VEC_TRAP;
  endproperty
  a_trap_entry: assert property (p_trap_entry) else $error("Trap not taken");

  property p_leave_clean;
    @(posedge sys_clk_in) disable iff (srst_in) $fell(in_reset_q) |-> !any_reset && !$past(pin_low);
  endproperty
  a_leave_clean: assert property (p_leave_clean) else $error("Reset left unsynchronised");

  c_trap: cover property (@(posedge sys_clk_in) state_q == ST_VECTOR && trap_q);
  c_irq: cover property (@(posedge sys_clk_in) state_q == ST_VECTOR && !trap_q);
  c_halt_wake: cover property (@(posedge sys_clk_in) state_q == ST_HALT ##1 state_q == ST_STAB);
endmodule // reset_and_interrupt_control

// >>> cpu_model.sv
// Behavioural core sequencer: instruction boundaries, traps and returns
`timescale 1ns/100ps
module cpu_model (
  input wire logic sys_clk_in,
  input wire logic core_reset_in,
  input wire logic cpu_run_in,
  input wire logic vector_load_in,
  input wire logic [15:0] vector_addr_in,
  input wire logic trap_req_in,
  input wire logic [7:0] svc_len_in,
  output logic insn_done_out,
  output logic trap_out,
  output logic ret_out
);
  logic [1:0] step_q = 2'h0;
  logic [8:0] svc_q = 9'h000;
  logic trap_used_q = 1'b0;
  initial begin
    insn_done_out = 1'b0;
    trap_out = 1'b0;
    ret_out = 1'b0;
  end
  always @(posedge sys_clk_in) begin
    step_q <= step_q + 2'h1;
    insn_done_out <= 1'b0;
    trap_out <= 1'b0;
    if (!trap_req_in) trap_used_q <= 1'b0;
    if (core_reset_in || !cpu_run_in) begin
      step_q <= 2'h0;
    end else if (step_q == 2'h3) begin
      insn_done_out <= 1'b1;
      trap_out <= trap_req_in & !trap_used_q;
      if (trap_req_in) trap_used_q <= 1'b1;
    end
  end
  // Service routine length set by the bench; no return after reset vector
  always @(posedge sys_clk_in) begin
    ret_out <= 1'b0;
    if (core_reset_in) begin
      svc_q <= 9'h000;
    end else if (vector_load_in && vector_addr_in != 16'hFFFE) begin
      svc_q <= {1'b0, svc_len_in} + 9'h001;
    end else if (svc_q == 9'h001) begin
      svc_q <= 9'h000;
      ret_out <= 1'b1;
    end else if (svc_q != 9'h000) begin
      svc_q <= svc_q - 9'h001;
    end
  end
endmodule // cpu_model

// >>> tb_top.sv
// Self-checking bench for reset sequencing and interrupt dispatch
`timescale 1ns/100ps
module tb_top;
  import rst_irq_pkg::*;
  localparam int RH = 16;
  localparam int SH = 16;
  // ****************
  // Wiring
  // ****************
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] src = 4'h0;
  logic [3:0] ext_pin = 4'hF;
  logic [3:0] pflag = 4'h0;
  logic wfi = 1'b0;
  logic halt = 1'b0;
  logic setm = 1'b0;
  logic clrm = 1'b0;
  logic trap_req = 1'b0;
  logic [7:0] svc_len = 8'h08;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pin_n, pin_out_n, pin_oe, core_rst, osc_en, run, push, pop, vload, insn, trap, ret;
  logic [15:0] vaddr;
  logic [7:0] ccr;
  logic [15:0] last_vec = 16'h0;
  logic pushed = 1'b0;
  logic last_push = 1'b0;
  logic [31:0] q;
  int n_vec = 0;
  int n_pop = 0;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #50 sys_clk_in = !sys_clk_in;
  // Pull-up on the reset pin when nobody drives it
  assign pin_n = (pin_oe === 1'b1) ? pin_out_n : !src[0];
  reset_and_interrupt_control #(.RESET_HOLD(RH), .STAB_HOLD(SH)) dut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(1'b1), .reset_pin_n_in(pin_n),
    .reset_pin_n_out(pin_out_n), .reset_pin_oe_out(pin_oe), .por_in(src[1]), .watchdog_in(src[2]),
    .brownout_detector_in(src[3]), .ext_pin_in(ext_pin), .periph_flag_in(pflag), .insn_done_in(insn),
    .trap_in(trap), .return_from_service_in(ret), .wfi_in(wfi), .halt_in(halt), .set_mask_in(setm),
    .clear_mask_in(clrm), .core_reset_out(core_rst), .osc_enable_out(osc_en), .cpu_run_out(run),
    .push_context_out(push), .pop_context_out(pop), .vector_load_out(vload), .vector_addr_out(vaddr),
    .condition_code_register_out(ccr), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  cpu_model core (
    .sys_clk_in(sys_clk_in), .core_reset_in(core_rst), .cpu_run_in(run), .vector_load_in(vload),
    .vector_addr_in(vaddr), .trap_req_in(trap_req), .svc_len_in(svc_len), .insn_done_out(insn),
    .trap_out(trap), .ret_out(ret));
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (push === 1'b1) pushed <= 1'b1;
    if (pop === 1'b1) n_pop <= n_pop + 1;
    if (vload === 1'b1) begin
      last_vec <= vaddr;
      last_push <= pushed;
      pushed <= 1'b0;
      n_vec <= n_vec + 1;
    end
    if (cycles == 60000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  function automatic logic [15:0] vec_of(input int s);
    // Externals first, then peripherals, one word apart each
    if (s < NUM_EXT) return VEC_EXT0 - 16'(s) * VEC_STEP;
    return VEC_PERIPH0 - 16'(s - NUM_EXT) * VEC_STEP;
  endfunction
  task automatic av(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) n_fail++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wait_ev(input bit on_pop, output int c);
    int base;
    base = on_pop ? n_pop : n_vec;
    c = 0;
    while ((on_pop ? n_pop : n_vec) == base && c < 5000) begin
      @(posedge sys_clk_in);
      c++;
    end
    if (c == 5000) chk(32'h0, 32'h1);
  endtask
  task automatic no_vec(input int c);
    int base;
    base = n_vec;
    cyc(c);
    chk(n_vec, base);
  endtask
  task automatic mask(input bit clr);
    if (clr) clrm <= 1'b1;
    else setm <= 1'b1;
    @(posedge sys_clk_in);
    clrm <= 1'b0;
    setm <= 1'b0;
  endtask
  // Serviced entry: vector, push before it, mask set
  task automatic entered(input int s);
    wait_ev(0, n);
    chk(last_vec, vec_of(s));
    chk(last_push, 1'b1);
    chk(ccr[CCR_MASK_BIT], 1'b1);
  endtask
  task automatic returned();
    av(1, ADDR_PEND, 32'h0);
    wait_ev(1, n);
    cyc(2);
    chk(ccr[CCR_MASK_BIT], 1'b0);
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    void'($urandom(4));
    cyc(16);
    srst_in <= 1'b0;
    wait_ev(0, n);
    chk(last_vec, VEC_RESET);
    for (int s = 0; s < 4; s++) begin
      src <= 4'h1 << s;
      cyc(s == 3 ? 40 : 8);
      chk(core_rst, 1'b1);
      if (s != 0) chk(pin_n, 1'b0);
      src <= 4'h0;
      wait_ev(0, n);
      chk(last_vec, VEC_RESET);
      chk(n >= RH + SH, 1'b1);
      chk(ccr[CCR_MASK_BIT], 1'b1);
    end
    src <= 4'h1;
    cyc(RH + SH + 20);
    chk(core_rst, 1'b1);
    src <= 4'h0;
    wait_ev(0, n);
    av(0, 4'h2, 32'h0);
    chk(q, UNMAPPED_DATA);
    av(1, ADDR_ENABLE, 32'hF);
    av(0, ADDR_ENABLE, 32'h0);
    chk(q[3:0], 4'hF);
    av(0, ADDR_STATUS, 32'h0);
    chk(q[15:8], ccr);
    for (int k = 0; k < 4; k++) begin
      svc_len <= 8'($urandom_range(40, 2));
      pflag <= 4'h1 << k;
      no_vec(30);
      av(0, ADDR_PEND, 32'h0);
      chk(q[NUM_EXT + k], 1'b1);
      mask(1);
      entered(NUM_EXT + k);
      pflag <= 4'h0;
      returned();
      mask(0);
    end
    svc_len <= 8'h28;
    ext_pin <= 4'b1010;
    pflag <= 4'h1;
    mask(1);
    entered(0);
    ext_pin <= 4'b1011;
    cyc(3);
    returned();
    entered(2);
    chk(last_vec, vec_of(2));
    ext_pin <= 4'hF;
    cyc(3);
    av(1, ADDR_PEND, 32'h0);
    wait_ev(1, n);
    entered(NUM_EXT);
    chk(last_vec, vec_of(NUM_EXT));
    pflag <= 4'h0;
    returned();
    mask(0);
    trap_req <= 1'b1;
    wait_ev(0, n);
    chk(last_vec, VEC_TRAP);
    trap_req <= 1'b0;
    wait_ev(1, n);
    av(1, ADDR_CTRL, 32'h2);
    mask(0);
    ext_pin <= 4'b1101;
    cyc(2);
    ext_pin <= 4'hF;
    cyc(5);
    mask(1);
    entered(1);
    wait_ev(1, n);
    no_vec(40);
    av(1, ADDR_CTRL, 32'h0);
    mask(0);
    pflag <= 4'h2;
    cyc(10);
    pflag <= 4'h0;
    av(1, ADDR_PEND, 32'h0);
    mask(1);
    no_vec(40);
    av(1, ADDR_ENABLE, 32'h0);
    pflag <= 4'h4;
    no_vec(30);
    av(1, ADDR_ENABLE, 32'hF);
    entered(NUM_EXT + 2);
    pflag <= 4'h0;
    returned();
    wfi <= 1'b1;
    cyc(1);
    wfi <= 1'b0;
    cyc(5);
    chk(run, 1'b0);
    pflag <= 4'h8;
    entered(NUM_EXT + 3);
    pflag <= 4'h0;
    returned();
    halt <= 1'b1;
    cyc(1);
    halt <= 1'b0;
    cyc(5);
    chk(osc_en, 1'b0);
    ext_pin <= 4'b0111;
    entered(3);
    chk(n >= SH, 1'b1);
    ext_pin <= 4'hF;
    cyc(3);
    returned();
    wrap_up();
  end
endmodule // tb_top
